// ===== design/itc_threshold_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "itc_cfg.svh"

module itc_threshold_bank (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // serial register port
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_SDI,
  output var  logic        SPI_SDO,
  output var  logic        SPI_SDO_OE,
  // conversion core
  input  wire logic        CONV_VALID,
  input  wire logic [15:0] CONV_RESULT,
  input  wire logic        AMP_REGULATED,
  output var  logic        CONV_ENABLE,
  // alert
  output var  logic        ALERT_N
);

  itc_pkg::itc_bank_st_t q;
  itc_pkg::itc_bank_st_t d;
  itc_pkg::itc_req_t     req;

  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [5:0]  func;

  function automatic logic [15:0] join_limit(input logic [7:0] hi, input logic [7:0] lo);
    join_limit = {hi, lo};
  endfunction

  function automatic logic [7:0] status_byte(input logic over_n, input logic band);
    status_byte = `ITC_RST_BYTE;
    status_byte[`ITC_OVER_BIT] = over_n;
    status_byte[`ITC_BAND_BIT] = band;
  endfunction

  function automatic logic [7:0] read_mux(input itc_pkg::itc_bank_st_t s, input logic [6:0] a);
    unique case (a)
      `ITC_OFS_ALERT_SEL: read_mux = s.alert_sel;
      `ITC_OFS_CONV_CFG:  read_mux = s.conv_cfg;
      `ITC_OFS_UL_LOW:    read_mux = s.ul_low_shadow;
      `ITC_OFS_UL_HIGH:   read_mux = s.ul_high;
      `ITC_OFS_LL_LOW:    read_mux = s.ll_low_shadow;
      `ITC_OFS_LL_HIGH:   read_mux = s.ll_high;
      `ITC_OFS_STATUS:    read_mux = status_byte(s.over_n, s.band);
      default:            read_mux = `ITC_RST_BYTE;
    endcase
  endfunction

  itc_spi_slave u_spi (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .cs_n_pin (SPI_CS_N),
    .sclk_pin (SPI_SCLK),
    .sdi_pin  (SPI_SDI),
    .sdo      (SPI_SDO),
    .sdo_oe   (SPI_SDO_OE),
    .req      (req),
    .rd_data  (q.rd_data)
  );

  // compares always use committed bytes, never the shadow
  assign upper_limit = join_limit(q.ul_high, q.ul_low_cmt);
  assign lower_limit = join_limit(q.ll_high, q.ll_low_cmt);
  assign func = q.alert_sel[`ITC_FUNC_MSB:0];

  always_comb begin
    d = q;
    d.amp_s1 = AMP_REGULATED;
    d.amp_s2 = q.amp_s1;
    if (req.rd) begin
      d.rd_data = read_mux(q, req.addr);
    end
    // writes land at any time; conversions are never held off
    if (req.wr) begin
      unique case (req.addr)
        `ITC_OFS_ALERT_SEL: begin
          d.alert_sel = req.wdata;
          if (req.wdata == `ITC_CLEAR_BYTE) begin
            d.over_n = 1'b1;
          end
        end
        `ITC_OFS_CONV_CFG: d.conv_cfg = req.wdata;
        `ITC_OFS_UL_LOW:   d.ul_low_shadow = req.wdata;
        `ITC_OFS_UL_HIGH: begin
          d.ul_high = req.wdata;
          d.ul_low_cmt = q.ul_low_shadow;
        end
        `ITC_OFS_LL_LOW:   d.ll_low_shadow = req.wdata;
        `ITC_OFS_LL_HIGH: begin
          d.ll_high = req.wdata;
          d.ll_low_cmt = q.ll_low_shadow;
        end
        default: ;
      endcase
    end
    // a new result beats a same-cycle clear, so no event is lost
    if (CONV_VALID) begin
      if (CONV_RESULT > upper_limit) begin
        d.over_n = 1'b0;
        d.band = 1'b0;
      end
      if (CONV_RESULT < lower_limit) begin
        d.band = 1'b1;
      end
    end
    d.conv_en = q.conv_cfg[`ITC_AMP_OVR_BIT] | q.amp_s2;
    if (func == `ITC_FUNC_HYST) begin
      d.alert_n = ~q.band;
    end else if (func == `ITC_FUNC_LATCH) begin
      d.alert_n = q.over_n;
    end else begin
      d.alert_n = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      q <= '0;
      q.alert_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign CONV_ENABLE = q.conv_en;
  assign ALERT_N = q.alert_n;

endmodule
`default_nettype wire

// ===== design/itc_cfg.svh
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH

// register offsets, 7-bit serial address
`define ITC_OFS_ALERT_SEL 7'h0A
`define ITC_OFS_CONV_CFG  7'h0C
`define ITC_OFS_UL_LOW    7'h16
`define ITC_OFS_UL_HIGH   7'h17
`define ITC_OFS_LL_LOW    7'h18
`define ITC_OFS_LL_HIGH   7'h19
`define ITC_OFS_STATUS    7'h20

// reset and clear values
`define ITC_RST_BYTE      8'h00
`define ITC_CLEAR_BYTE    8'h00

// field positions
`define ITC_AMP_OVR_BIT   0
`define ITC_BAND_BIT      2
`define ITC_OVER_BIT      3
`define ITC_FUNC_MSB      5

// alert function patterns
`define ITC_FUNC_HYST     6'h10
`define ITC_FUNC_LATCH    6'h08

// serial frame: 8 command bits then 8 data bits
`define ITC_CMD_BITS      5'h08
`define ITC_FRAME_BITS    5'h10

`endif

// ===== design/itc_pkg.sv
package itc_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } itc_req_t;

  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       sdi_s1;
    logic       sdi_s2;
    logic [4:0] cnt;
    logic [15:0] shin;
    logic [7:0] shout;
    logic       rd_frame;
    itc_req_t   req;
    logic       sdo;
    logic       sdo_oe;
  } itc_spi_st_t;

  typedef struct packed {
    logic [7:0] conv_cfg;
    logic [7:0] alert_sel;
    logic [7:0] ul_low_shadow;
    logic [7:0] ul_low_cmt;
    logic [7:0] ul_high;
    logic [7:0] ll_low_shadow;
    logic [7:0] ll_low_cmt;
    logic [7:0] ll_high;
    logic       over_n;
    logic       band;
    logic [7:0] rd_data;
    logic       amp_s1;
    logic       amp_s2;
    logic       conv_en;
    logic       alert_n;
  } itc_bank_st_t;

endpackage

// ===== design/itc_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "itc_cfg.svh"

module itc_spi_slave (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // serial pins
  input  wire logic            cs_n_pin,
  input  wire logic            sclk_pin,
  input  wire logic            sdi_pin,
  output var  logic            sdo,
  output var  logic            sdo_oe,
  // register side
  output var  itc_pkg::itc_req_t req,
  input  wire logic [7:0]      rd_data
);

  itc_pkg::itc_spi_st_t q;
  itc_pkg::itc_spi_st_t d;

  logic rise;
  logic fall;
  logic [15:0] shifted;

  always_comb begin
    d = q;
    d.req.wr = 1'b0;
    d.req.rd = 1'b0;
    d.cs_s1 = cs_n_pin;
    d.cs_s2 = q.cs_s1;
    d.sck_s1 = sclk_pin;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.sdi_s1 = sdi_pin;
    d.sdi_s2 = q.sdi_s1;
    rise = q.sck_s2 & ~q.sck_s3;
    fall = ~q.sck_s2 & q.sck_s3;
    shifted = {q.shin[14:0], q.sdi_s2};
    if (q.cs_s2) begin
      // frame aborted or idle: drop partial command
      d.cnt = 5'h00;
      d.rd_frame = 1'b0;
      d.sdo = 1'b0;
      d.sdo_oe = 1'b0;
    end else begin
      d.sdo_oe = 1'b1;
      if (rise && q.cnt < `ITC_FRAME_BITS) begin
        d.shin = shifted;
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == `ITC_CMD_BITS - 5'h01) begin
          d.rd_frame = shifted[7];
          d.req.addr = shifted[6:0];
          d.req.rd = shifted[7];
        end
        if (q.cnt == `ITC_FRAME_BITS - 5'h01 && !q.rd_frame) begin
          d.req.addr = shifted[14:8];
          d.req.wdata = shifted[7:0];
          d.req.wr = 1'b1;
        end
      end
      // data out changes on the falling edge, ahead of the next sample
      if (fall && q.rd_frame) begin
        if (q.cnt == `ITC_CMD_BITS) begin
          d.sdo = rd_data[7];
          d.shout = {rd_data[6:0], 1'b0};
        end else if (q.cnt > `ITC_CMD_BITS && q.cnt < `ITC_FRAME_BITS) begin
          d.sdo = q.shout[7];
          d.shout = {q.shout[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.cs_s1 <= 1'b1;
      q.cs_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign req = q.req;
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;

endmodule
`default_nettype wire

// ===== test/itc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module itc_checker (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // serial port
  input wire logic        SPI_CS_N,
  input wire logic        SPI_SCLK,
  input wire logic        SPI_SDI,
  input wire logic        SPI_SDO,
  input wire logic        SPI_SDO_OE,
  // conversion and alert
  input wire logic        CONV_VALID,
  input wire logic [15:0] CONV_RESULT,
  input wire logic        AMP_REGULATED,
  input wire logic        CONV_ENABLE,
  input wire logic        ALERT_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  // cycles since select was low; register writes land inside this span
  logic [3:0] cs_age_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) cs_age_q <= 4'hF;
    else if (!SPI_CS_N) cs_age_q <= 4'h0;
    else if (cs_age_q != 4'hF) cs_age_q <= cs_age_q + 4'h1;
  end
  AST_RST_OE: assert property (!RST_N |=> !SPI_SDO_OE)
    else $error("sdo driven after reset");
  AST_RST_ALERT: assert property (!RST_N |=> ALERT_N)
    else $error("alert low after reset");
  AST_RST_EN: assert property (!RST_N |=> !CONV_ENABLE)
    else $error("conversion enabled after reset");
  AST_OE_ON: assert property (disable iff (!RST_N) $fell(SPI_CS_N) |-> ##[1:4] SPI_SDO_OE)
    else $error("sdo not driven in frame");
  AST_OE_OFF: assert property (disable iff (!RST_N) SPI_CS_N [*5] |-> !SPI_SDO_OE)
    else $error("sdo driven while deselected");
  AST_EN_AMP: assert property (disable iff (!RST_N) AMP_REGULATED [*8] |-> CONV_ENABLE)
    else $error("regulated but not converting");
  AST_ALERT_CAUSE: assert property (disable iff (!RST_N)
    $changed(ALERT_N) |-> $past(CONV_VALID, 2) || cs_age_q < 4'h8)
    else $error("alert moved without cause");
  AST_SDO_FALL: assert property (disable iff (!RST_N)
    SPI_SDO_OE && $changed(SPI_SDO) |-> !$past(SPI_SCLK))
    else $error("sdo moved with sclk high");
endmodule
bind itc_threshold_bank itc_checker u_chk (.*);
`default_nettype wire

// ===== test/itc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module itc_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic sdi,
  input  wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  // mode 0 frame; 8-cycle phases keep sclk within the sync limit
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= f[i];
      repeat (8) @(posedge clk);
      if (i < 8) rd[i] = sdo;
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    // released line shows the inverse, never a stale bit
    sdi  <= ~f[0];
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== test/itc_threshold_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "itc_cfg.svh"
module itc_threshold_bank_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, conv_en, alert_n;
  logic        conv_valid = 1'b0;
  logic [15:0] conv_result = 16'h0000;
  logic        amp_reg = 1'b0;
  logic [6:0]  regs [8] = '{7'h05, `ITC_OFS_ALERT_SEL, `ITC_OFS_CONV_CFG, `ITC_OFS_UL_LOW,
                            `ITC_OFS_UL_HIGH, `ITC_OFS_LL_LOW, `ITC_OFS_LL_HIGH, `ITC_OFS_STATUS};
  int          err_count = 0;
  int          n_compared = 0;
  always #2.5 clk = ~clk;
  itc_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  itc_threshold_bank u_dut (.SYS_CLK(clk), .RST_N(rst_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
    .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .CONV_VALID(conv_valid),
    .CONV_RESULT(conv_result), .AMP_REGULATED(amp_reg), .CONV_ENABLE(conv_en),
    .ALERT_N(alert_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.xfer({1'b1, a, 8'h00}, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    u_host.xfer({1'b0, a, v}, d);
  endtask
  task automatic conv(input logic [15:0] r);
    conv_result <= r;
    conv_valid  <= 1'b1;
    @(posedge clk);
    conv_valid  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, sdo_oe}, 8'h00);
    foreach (regs[i]) rd(regs[i], 8'h00);
    chk({7'h00, conv_en}, 8'h00);
    amp_reg <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h00, conv_en}, 8'h01);
    amp_reg <= 1'b0;
    repeat (8) @(posedge clk);
    chk({7'h00, conv_en}, 8'h00);
    wr(`ITC_OFS_CONV_CFG, 8'h01);
    chk({7'h00, conv_en}, 8'h01);
    wr(`ITC_OFS_STATUS, 8'hFF);
    rd(`ITC_OFS_STATUS, 8'h00);
    wr(`ITC_OFS_ALERT_SEL, 8'h08);
    chk({7'h00, alert_n}, 8'h00);
    wr(`ITC_OFS_ALERT_SEL, 8'h00);
    rd(`ITC_OFS_STATUS, 8'h08);
    wr(`ITC_OFS_ALERT_SEL, 8'h08);
    chk({7'h00, alert_n}, 8'h01);
    // low byte alone must not move the limit off zero
    wr(`ITC_OFS_UL_LOW, 8'h34);
    rd(`ITC_OFS_UL_LOW, 8'h34);
    rd(`ITC_OFS_UL_HIGH, 8'h00);
    conv(16'h0010);
    rd(`ITC_OFS_STATUS, 8'h00);
    chk({7'h00, alert_n}, 8'h00);
    wr(`ITC_OFS_ALERT_SEL, 8'h00);
    wr(`ITC_OFS_UL_HIGH, 8'h12);
    conv(16'h1234);
    rd(`ITC_OFS_STATUS, 8'h08);
    conv(16'h1235);
    rd(`ITC_OFS_STATUS, 8'h00);
    wr(`ITC_OFS_ALERT_SEL, 8'h00);
    wr(`ITC_OFS_LL_HIGH, 8'h10);
    wr(`ITC_OFS_LL_LOW, 8'hFF);
    rd(`ITC_OFS_LL_LOW, 8'hFF);
    rd(`ITC_OFS_LL_HIGH, 8'h10);
    conv(16'h1000);
    rd(`ITC_OFS_STATUS, 8'h08);
    conv(16'h0FFF);
    rd(`ITC_OFS_STATUS, 8'h0C);
    wr(`ITC_OFS_ALERT_SEL, 8'h10);
    chk({7'h00, alert_n}, 8'h00);
    conv(16'h1234);
    rd(`ITC_OFS_STATUS, 8'h0C);
    conv(16'h1235);
    rd(`ITC_OFS_STATUS, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    // a function code outside the two compares keeps alert idle
    conv(16'h0FFF);
    wr(`ITC_OFS_ALERT_SEL, 8'h01);
    chk({7'h00, alert_n}, 8'h01);
    rd(`ITC_OFS_STATUS, 8'h04);
    end_of_test;
  end
endmodule
`default_nettype wire
